/* dpc_pin_cell.sv */
// Double data rate pin cell with peripheral control bus and APB register access.
//
// Operation
// - Twelve line bus: six enables, six clock-enables.
// - Each line from internal logic or fast pin.
// - Output-enable lines only drive pin output enable.
// - Clock-enables; lines 0,2 clock, 1,3 OE, 4,5 clear.
// - Input register has own clock and enable.
// - Output and OE registers share clock, enable.
// - Input delay: off plus three levels.
// - One clear-or-preset source, selectable per cell.
// - Registers reset low; the clear loads the configured level, clear or preset.
// - Double rate input, output and bidirectional modes.
// - Input registers sample alternate clock edges.
// - Latch aligns both input bits to rising edge.
// - Output loads on rise; clock high first, low second.
// - Bidirectional mode is both double rate paths.
// - Falling-edge OE register delays enable activation.
// - Two input regs, latch, two output, two OE.
`timescale 1ns/100ps
module dpc_pin_cell
    import dpc_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                pin_i,
    output logic                     pin_o,
    output logic                     pin_oe,
    input  wire logic [NLINE-1:0]    fast_oe_i,
    input  wire logic [NLINE-1:0]    fast_ce_i
);

    // ==========================================================
    // Register file
    // The map holds five words: control, line source, line drive, transmit
    // request and receive status. The receive word is read only, and any
    // other offset is refused with pslverr while its write is dropped.
    // Fields above the width of a register read back as zero, so software
    // may write whole words without masking.
    logic [CTRL_W-1:0]  ctrl_q;
    logic [NCTRL-1:0]   src_q;
    logic [NCTRL-1:0]   drive_q;
    logic [TX_W-1:0]    tx_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;

    wire        apb_setup = psel & ~penable;
    wire        apb_wr    = psel & penable & pready_q & pwrite;
    wire        hit_ctrl  = (paddr == OFF_CTRL);
    wire        hit_src   = (paddr == OFF_SRC);
    wire        hit_drive = (paddr == OFF_DRIVE);
    wire        hit_tx    = (paddr == OFF_TX);
    wire        hit_rx    = (paddr == OFF_RX);
    wire        hit_any   = hit_ctrl | hit_src | hit_drive | hit_tx | hit_rx;
    wire [RX_W-1:0] rx_word;
    wire [31:0] rd_mux;

    assign rd_mux = hit_ctrl  ? {{(32-CTRL_W){1'b0}}, ctrl_q}  :
                    hit_src   ? {{(32-NCTRL){1'b0}}, src_q}    :
                    hit_drive ? {{(32-NCTRL){1'b0}}, drive_q}  :
                    hit_tx    ? {{(32-TX_W){1'b0}}, tx_q}      :
                    hit_rx    ? {{(32-RX_W){1'b0}}, rx_word}   : RST_WORD;

    // Zero-wait slave: pready rises in every access phase.
    // Read data are captured at the setup edge and held until the next
    // setup, so the master may take them at the access edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= RST_WORD;
        end else begin
            pready_q  <= apb_setup;
            pslverr_q <= apb_setup & ~hit_any;
            if (apb_setup) begin
                prdata_q <= pwrite ? RST_WORD : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= RST_WORD[CTRL_W-1:0];
            src_q   <= RST_WORD[NCTRL-1:0];
            drive_q <= RST_WORD[NCTRL-1:0];
            tx_q    <= RST_WORD[TX_W-1:0];
        end else if (apb_wr) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
            if (hit_src) begin
                src_q <= pwdata[NCTRL-1:0];
            end
            if (hit_drive) begin
                drive_q <= pwdata[NCTRL-1:0];
            end
            if (hit_tx) begin
                tx_q <= pwdata[TX_W-1:0];
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ==========================================================
    // Configuration fields
    // Every field is a plain slice of the control word; nothing is decoded
    // here, so a new control write takes effect on the very next edge.
    // Software should change clock or enable selections only while the
    // affected lines are quiet, or a false cell clock edge may be seen.
    wire       ddr_in   = ctrl_q[CTRL_DDR_IN];
    wire       ddr_out  = ctrl_q[CTRL_DDR_OUT];
    wire       clr_lvl  = ctrl_q[CTRL_PRESET];
    wire [1:0] iclk_sel = ctrl_q[CTRL_ICLK +: 2];
    wire [1:0] oclk_sel = ctrl_q[CTRL_OCLK +: 2];
    wire [2:0] ice_sel  = ctrl_q[CTRL_ICE +: 3];
    wire [2:0] oce_sel  = ctrl_q[CTRL_OCE +: 3];
    wire [2:0] oe_sel   = ctrl_q[CTRL_OESEL +: 3];
    wire [1:0] clr_sel  = ctrl_q[CTRL_CLR +: 2];
    wire [1:0] dly_sel  = ctrl_q[CTRL_DLY +: 2];

    // ==========================================================
    // Peripheral control bus
    // Fast pins are asynchronous, so they pass two flip-flops first.
    // The synchroniser costs two cycles of latency on every fast line, which
    // is accepted in exchange for freedom from metastable control levels.
    // Lines driven from the drive register need no such stage.
    logic [NCTRL-1:0] fast_s1_q;
    logic [NCTRL-1:0] fast_s2_q;
    logic [NCTRL-1:0] line;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_s1_q <= RST_WORD[NCTRL-1:0];
            fast_s2_q <= RST_WORD[NCTRL-1:0];
        end else begin
            fast_s1_q <= {fast_ce_i, fast_oe_i};
            fast_s2_q <= fast_s1_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCTRL; gi++) begin : g_line
            assign line[gi] = src_q[gi] ? fast_s2_q[gi] : drive_q[gi];
        end
    endgenerate

    wire [NLINE-1:0] oe_line = line[NLINE-1:0];
    wire [NLINE-1:0] ce_line = line[NCTRL-1:NLINE];

    // Only the enable lines and clock-enables 1 and 3 reach the pin enable.
    // Selector codes above the enable lines pick clock-enable one or three.
    wire oe_gate = (oe_sel <  OESEL_CE1) ? oe_line[oe_sel]  :
                   (oe_sel == OESEL_CE1) ? ce_line[LN_OE_A] : ce_line[LN_OE_B];

    wire i_ce = (ice_sel >= CESEL_ON) ? 1'b1 : ce_line[ice_sel];
    wire o_ce = (oce_sel >= CESEL_ON) ? 1'b1 : ce_line[oce_sel];

    wire cell_clr = (clr_sel == CLRSEL_LA) ? ce_line[LN_CLR_A] :
                    (clr_sel == CLRSEL_LB) ? ce_line[LN_CLR_B] : 1'b0;

    // ==========================================================
    // Cell clocks
    // The cell clock is a level sampled by pclk, so each half period lasts
    // at least one pclk cycle; the divider gives the fastest legal rate.
    // Edges are found by comparing each clock with its value one cycle
    // earlier; both history bits reset low, matching the divider's reset
    // level, so the divider gives no false edge after reset.
    logic div_q;
    logic iclk_prev_q;
    logic oclk_prev_q;

    wire iclk = (iclk_sel == CLKSEL_DIV) ? div_q :
                (iclk_sel == CLKSEL_LA)  ? ce_line[LN_CLK_A] : ce_line[LN_CLK_B];
    wire oclk = (oclk_sel == CLKSEL_DIV) ? div_q :
                (oclk_sel == CLKSEL_LA)  ? ce_line[LN_CLK_A] : ce_line[LN_CLK_B];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q       <= 1'b0;
            iclk_prev_q <= 1'b0;
            oclk_prev_q <= 1'b0;
        end else begin
            div_q       <= ~div_q;
            iclk_prev_q <= iclk;
            oclk_prev_q <= oclk;
        end
    end

    wire i_rise = iclk & ~iclk_prev_q;
    wire i_fall = ~iclk & iclk_prev_q;
    wire o_rise = oclk & ~oclk_prev_q;
    wire o_fall = ~oclk & oclk_prev_q;

    // ==========================================================
    // Input path with programmable delay
    // The delay setting picks one tap of a short shift chain behind the
    // synchroniser: no delay, then one, two or three extra cycles.
    // The chain always runs, so changing the setting only moves the tap.
    logic               pin_s1_q;
    logic               pin_s2_q;
    logic [DLY_MAX-1:0] dly_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            dly_q    <= RST_WORD[DLY_MAX-1:0];
        end else begin
            pin_s1_q <= pin_i;
            pin_s2_q <= pin_s1_q;
            dly_q    <= {dly_q[DLY_MAX-2:0], pin_s2_q};
        end
    end

    wire pin_in = (dly_sel == DLY_OFF) ? pin_s2_q :
                  (dly_sel == DLY_ONE) ? dly_q[0] :
                  (dly_sel == DLY_TWO) ? dly_q[1] : dly_q[2];

    // ==========================================================
    // Cell registers
    // Every cell register but rx_first_q and rx_second_q takes the same clear source and level.
    // The clear acts synchronously, after a fast-pin clear line has passed the
    // synchroniser, and wins over any clock edge in the same cycle.
    // A preset level of one drives every register high instead of low.
    // The latch is modelled as a register loaded on the falling cell edge
    // from the rising-edge register, which keeps all state on pclk.
    logic in_hi_q;
    logic in_lo_q;
    logic in_latch_q;
    logic out_a_q;
    logic out_b_q;
    logic oe_a_q;
    logic oe_n_q;
    logic rx_first_q;
    logic rx_second_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_hi_q    <= 1'b0;
            in_latch_q <= 1'b0;
        end else if (cell_clr) begin
            in_hi_q    <= clr_lvl;
            in_latch_q <= clr_lvl;
        end else if (i_ce) begin
            if (i_rise) begin
                in_hi_q <= pin_in;
            end
            if (i_fall) begin
                in_latch_q <= in_hi_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_lo_q <= 1'b0;
        end else if (cell_clr) begin
            in_lo_q <= clr_lvl;
        end else if (i_ce && i_fall && ddr_in) begin
            in_lo_q <= pin_in;
        end
    end

    // Both captured bits are presented together at the input rising edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_first_q  <= 1'b0;
            rx_second_q <= 1'b0;
        end else if (i_ce && i_rise) begin
            rx_first_q  <= ddr_in ? in_latch_q : pin_in;
            rx_second_q <= ddr_in ? in_lo_q : 1'b0;
        end
    end

    // Apart from the clear, a disabled clock enable leaves every cell register as it was.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
            oe_a_q  <= 1'b0;
        end else if (cell_clr) begin
            out_a_q <= clr_lvl;
            out_b_q <= clr_lvl;
            oe_a_q  <= clr_lvl;
        end else if (o_ce && o_rise) begin
            out_a_q <= tx_q[TX_FIRST];
            out_b_q <= tx_q[TX_SECOND];
            oe_a_q  <= tx_q[TX_OE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_n_q <= 1'b0;
        end else if (cell_clr) begin
            oe_n_q <= clr_lvl;
        end else if (o_ce && o_fall) begin
            oe_n_q <= oe_a_q;
        end
    end

    // ==========================================================
    // Pin drive
    // The pin is registered, so it follows the cell clock one pclk late.
    // In double rate output the first bit stands while the cell clock is
    // high and the second while it is low. The enable in that mode needs
    // both enable registers, so it drops at once but rises only after the
    // falling edge that follows its request.
    logic pin_o_q;
    logic pin_oe_q;

    wire pin_d    = (ddr_out && !oclk) ? out_b_q : out_a_q;
    wire pin_oe_d = oe_gate & (ddr_out ? (oe_a_q & oe_n_q) : oe_a_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_o_q  <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_o_q  <= pin_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign pin_o   = pin_o_q;
    assign pin_oe  = pin_oe_q;
    assign rx_word = {pin_oe_q, pin_in, rx_second_q, rx_first_q};

endmodule

/* dpc_pin_cell_chk.sv */
// Checker for the pin cell: bus answers, clear forcing and clock-enable hold.
`timescale 1ns/100ps
module dpc_pin_cell_chk
    import dpc_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              pin_i,
    input wire logic              pin_o,
    input wire logic              pin_oe,
    input wire logic [NLINE-1:0]  fast_oe_i,
    input wire logic [NLINE-1:0]  fast_ce_i
);
    // ==========================================================
    // Shadow configuration, updated at the edge where a write lands.
    logic [31:0] ctrl_q;
    logic [31:0] src_q;
    wire         acc_w   = psel && penable && pready;
    wire         setup_w = psel && !penable;
    wire         clr_w   = ctrl_q[17:16] == CLRSEL_LA && src_q[10] && fast_ce_i[4];
    wire         hold_w  = !ctrl_q[1] && ctrl_q[12:10] == 3'h0 && src_q[6] && !fast_ce_i[0]
                           && ctrl_q[17:16] == CLRSEL_NONE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h0;
            src_q  <= 32'h0;
        end else if (acc_w && pwrite && paddr == OFF_CTRL) begin
            ctrl_q <= pwdata;
        end else if (acc_w && pwrite && paddr == OFF_SRC) begin
            src_q <= pwdata;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    setup_ready_a: assert property (setup_w |=> pready) else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    unmapped_err_a: assert property (setup_w && paddr > OFF_RX |=> pslverr) else $error("unmapped not refused");
    err_zero_a: assert property (acc_w && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
    ctrl_back_a: assert property (
        acc_w && !pwrite && paddr == OFF_CTRL |-> prdata == {12'h000, ctrl_q[19:0]})
        else $error("control readback wrong");
    clear_level_a: assert property (
        (clr_w && $stable({ctrl_q, src_q}))[*6] |-> pin_o == ctrl_q[2])
        else $error("clear level not forced");
    ce_hold_a: assert property (
        (hold_w && $stable({ctrl_q, src_q}))[*6] |-> $stable(pin_o))
        else $error("pin changed with enable low");

    cover property (clr_w[*6]);
    cover property (hold_w[*6]);
    cover property (acc_w && pslverr);
endmodule

bind dpc_pin_cell dpc_pin_cell_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .fast_oe_i(fast_oe_i), .fast_ce_i(fast_ce_i));

/* dpc_pin_cell_tb.sv */
// Self-checking bench for the pin cell: register access, pin paths, clear and hold.
`timescale 1ns/100ps
module dpc_pin_cell_tb
    import dpc_pkg::*;
;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              pin_i;
    logic              pin_o;
    logic              pin_oe;
    logic [NLINE-1:0]  fast_oe_i;
    logic [NLINE-1:0]  fast_ce_i;
    logic              drv_val;
    logic [33:0]       note;
    logic [33:0]       exp_q[$];
    logic [31:0]       v;
    int                num_errors;
    int                cmp_count;
    int                cyc;
    int                ones;

    dpc_pin_cell uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .fast_oe_i(fast_oe_i), .fast_ce_i(fast_ce_i));
    dpc_pin_partner u_far (.pin_o(pin_o), .pin_oe(pin_oe), .drv_val(drv_val), .pin_i(pin_i));

    // ==========================================================
    // Helpers
    always #12.5 pclk = ~pclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One transfer; the note holds read flag, expected error and expected read data.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        exp_q.push_back({!w, e, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = exp_q.pop_front();
            chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
            if (note[33]) begin
                chk("prdata", note[31:0], prdata);
            end
        end
    end

    // The whole run needs about three hundred cycles.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            finish_test();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fast_oe_i = '0;
        fast_ce_i = '0;
        drv_val = 1'b0;
        void'($urandom(32));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) apb(0, 12'(4 * i), 32'h0, 0);
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            v[19:18] = i[1:0];
            fast_oe_i <= v[31:26];
            apb(1, OFF_CTRL, v, 0);
            apb(0, OFF_CTRL, v & 32'h000F_FFFF, 0);
            apb(1, OFF_SRC, v, 0);
            apb(0, OFF_SRC, v & 32'h0000_0FFF, 0);
            apb(1, 12'h014 + 12'(4 * i), v, 1);
            apb(0, 12'h014, 32'h0, 1);
        end
        // Double rate both ways, divider clocks, enables on, output enable gated by CE1.
        apb(1, OFF_SRC, 32'h0, 0);
        apb(1, OFF_DRIVE, 32'h0000_0080, 0);
        apb(1, OFF_CTRL, 32'h0000_DB03, 0);
        for (int t = 0; t < 4; t++) begin
            apb(1, OFF_TX, 32'(t) | 32'h4, 0);
            repeat (6) @(posedge pclk);
            ones = 0;
            repeat (8) begin
                @(posedge pclk);
                ones += pin_o;
            end
            chk("pin_o high count", 32'(4 * (t[0] + t[1])), 32'(ones));
            chk("pin_oe", 32'h1, {31'h0, pin_oe});
        end
        for (int b = 0; b < 2; b++) begin
            drv_val <= b[0];
            apb(1, OFF_TX, 32'h0, 0);
            repeat (10) @(posedge pclk);
            chk("pin_oe", 32'h0, {31'h0, pin_oe});
            apb(0, OFF_RX, {29'h0, b[0], b[0], b[0]}, 0);
        end
        // The same clear line reaches every register of the cell except rx_first_q and rx_second_q.
        apb(1, OFF_SRC, 32'h0000_0400, 0);
        fast_ce_i[4] <= 1'b1;
        for (int l = 0; l < 2; l++) begin
            drv_val <= l[0];
            apb(1, OFF_CTRL, 32'h0001_DB03 | 32'(l << 2), 0);
            repeat (10) @(posedge pclk);
            chk("pin_o", 32'(l), {31'h0, pin_o});
            chk("pin_oe", 32'(l), {31'h0, pin_oe});
            apb(0, OFF_RX, {28'h0, l[0], l[0], l[0], l[0]}, 0);
        end
        fast_ce_i[4] <= 1'b0;
        // Single rate, output clock enable from fast CE0, output enable gated by CE1, input enable always on.
        apb(1, OFF_SRC, 32'h0000_0040, 0);
        apb(1, OFF_CTRL, 32'h0000_C300, 0);
        drv_val <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            fast_ce_i[0] <= (k != 1);
            apb(1, OFF_TX, (k == 0) ? 32'h0 : 32'h5, 0);
            repeat (8) @(posedge pclk);
            chk("pin_o", 32'(k == 2), {31'h0, pin_o});
            chk("pin_oe", 32'(k == 2), {31'h0, pin_oe});
            apb(0, OFF_RX, {28'h0, 1'(k == 2), 3'h5}, 0);
        end
        finish_test();
    end
endmodule

/* dpc_pin_partner.sv */
// Model of the external device sharing the cell's two-way pin.
`timescale 1ns/100ps
module dpc_pin_partner (
    input  wire logic pin_o,
    input  wire logic pin_oe,
    input  wire logic drv_val,
    output logic      pin_i
);
    // ==========================================================
    // Wire level
    // The device lets go of the pin while the cell drives, so the cell never fights it.
    assign pin_i = pin_oe ? pin_o : drv_val;
endmodule

/* dpc_pkg.sv */
// Constants for the double data rate pin cell: register map, field layout and selector codes.
package dpc_pkg;

    // ==========================================================
    // Register map
    localparam int         ADDR_W     = 12;
    localparam logic [11:0] OFF_CTRL  = 12'h000;
    localparam logic [11:0] OFF_SRC   = 12'h004;
    localparam logic [11:0] OFF_DRIVE = 12'h008;
    localparam logic [11:0] OFF_TX    = 12'h00C;
    localparam logic [11:0] OFF_RX    = 12'h010;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;

    // ==========================================================
    // CTRL field positions
    localparam int CTRL_DDR_IN  = 0;
    localparam int CTRL_DDR_OUT = 1;
    localparam int CTRL_PRESET  = 2;
    localparam int CTRL_ICLK    = 3;
    localparam int CTRL_OCLK    = 5;
    localparam int CTRL_ICE     = 7;
    localparam int CTRL_OCE     = 10;
    localparam int CTRL_OESEL   = 13;
    localparam int CTRL_CLR     = 16;
    localparam int CTRL_DLY     = 18;
    localparam int CTRL_W       = 20;

    // ==========================================================
    // Peripheral control bus
    localparam int NLINE    = 6;
    localparam int NCTRL    = 12;
    localparam int LN_CLK_A = 0;
    localparam int LN_OE_A  = 1;
    localparam int LN_CLK_B = 2;
    localparam int LN_OE_B  = 3;
    localparam int LN_CLR_A = 4;
    localparam int LN_CLR_B = 5;

    // ==========================================================
    // Selector codes
    localparam logic [1:0] CLKSEL_DIV  = 2'h0;
    localparam logic [1:0] CLKSEL_LA   = 2'h1;
    localparam logic [1:0] CLRSEL_NONE = 2'h0;
    localparam logic [1:0] CLRSEL_LA   = 2'h1;
    localparam logic [1:0] CLRSEL_LB   = 2'h2;
    localparam logic [2:0] CESEL_ON    = 3'h6;
    localparam logic [2:0] OESEL_CE1   = 3'h6;
    localparam logic [1:0] DLY_OFF     = 2'h0;
    localparam logic [1:0] DLY_ONE     = 2'h1;
    localparam logic [1:0] DLY_TWO     = 2'h2;
    localparam int         DLY_MAX     = 3;

    // ==========================================================
    // TX and RX field positions
    localparam int TX_FIRST  = 0;
    localparam int TX_SECOND = 1;
    localparam int TX_OE     = 2;
    localparam int TX_W      = 3;
    localparam int RX_W      = 4;

endpackage
